// File: hw/qgcfg_pkg.sv
// Constants shared by the quad UART global configuration block.
package qgcfg_pkg;
	// Address map boundaries.
	localparam logic [7:0] CH_SPACE_END = 8'h3F;
	localparam logic [7:0] RSVD_END     = 8'h7F;
	localparam logic [7:0] CFG_BASE     = 8'h80;
	localparam logic [7:0] CFG_END      = 8'h8F;
	localparam int         CH_SEL_LSB   = 4;
	localparam int         LEGACY_BIT   = 3;
	// Global configuration register offsets.
	localparam logic [7:0] ADDR_PEND    = 8'h80;
	localparam logic [7:0] ADDR_SRC_LO  = 8'h81;
	localparam logic [7:0] ADDR_SRC_HI  = 8'h82;
	localparam logic [7:0] ADDR_SPARE   = 8'h83;
	localparam logic [7:0] ADDR_TCTRL   = 8'h84;
	localparam logic [7:0] ADDR_TSPARE  = 8'h85;
	localparam logic [7:0] ADDR_TLOW    = 8'h86;
	localparam logic [7:0] ADDR_THIGH   = 8'h87;
	localparam logic [7:0] ADDR_OVS     = 8'h88;
	localparam logic [7:0] ADDR_SPARE_A = 8'h89;
	localparam logic [7:0] ADDR_SRESET  = 8'h8A;
	localparam logic [7:0] ADDR_SLEEP   = 8'h8B;
	localparam logic [7:0] ADDR_REV     = 8'h8C;
	localparam logic [7:0] ADDR_PART    = 8'h8D;
	localparam logic [7:0] ADDR_BCAST   = 8'h8E;
	// Values after reset.
	localparam logic [7:0] RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_RELOAD  = 16'h0000;
	// Field positions.
	localparam int TCTRL_IRQ_EN  = 0;
	localparam int TCTRL_START   = 1;
	localparam int TCTRL_ONESHOT = 2;
	localparam int TCTRL_EXTCLK  = 3;
	localparam int TCTRL_W       = 4;
	localparam int SLEEP_WAKE_EN = 4;
	localparam int SLEEP_W       = 5;
	localparam int BCAST_BIT     = 0;
	// Read data appears this many edges after the read strobe.
	localparam int READ_LATENCY  = 2;
	// Per-channel interrupt source codes.
	typedef enum logic [2:0] {
		CODE_NONE    = 3'b000,
		CODE_RX_LINE = 3'b001,
		CODE_RX_TOUT = 3'b010,
		CODE_TX_MT   = 3'b011,
		CODE_MODEM   = 3'b100,
		CODE_TIMER   = 3'b111
	} qgcfg_code_type;
endpackage

// File: hw/qgcfg_src_enc.sv
// Priority encoder giving one channel's interrupt source code.
`timescale 1ns/1ps
`default_nettype none
module qgcfg_src_enc #(
	parameter bit HAS_TIMER = 1'b0
) (
	// Enabled interrupt requests of the channel.
	input  wire logic                      rx_line,
	input  wire logic                      rx_tout,
	input  wire logic                      tx_empty,
	input  wire logic                      modem,
	input  wire logic                      timer,
	// Encoded source.
	output qgcfg_pkg::qgcfg_code_type      code
);
	// Highest priority first; the timer code only exists on channel 0.
	always_comb
	begin
		if (rx_line)
			code = qgcfg_pkg::CODE_RX_LINE;
		else if (rx_tout)
			code = qgcfg_pkg::CODE_RX_TOUT;
		else if (tx_empty)
			code = qgcfg_pkg::CODE_TX_MT;
		else if (modem)
			code = qgcfg_pkg::CODE_MODEM;
		else if (HAS_TIMER && timer)
			code = qgcfg_pkg::CODE_TIMER;
		else
			code = qgcfg_pkg::CODE_NONE;
	end
endmodule
`default_nettype wire

// File: hw/qgcfg_timer.sv
// General purpose 16-bit down counter with time-out pulse.
`timescale 1ns/1ps
`default_nettype none
module qgcfg_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset.
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Control.
	input  wire logic             start,
	input  wire logic             oneshot,
	input  wire logic             tick,
	input  wire logic [WIDTH-1:0] reload,
	// One-cycle pulse at each time-out.
	output logic                  timeout
);
	if (WIDTH < 2)
	begin : g_bad_width
		$error("qgcfg_timer: WIDTH too small");
	end

	logic [WIDTH-1:0] count;
	logic             start_q;
	logic             done;

	// Stop pauses the count; a fresh start reloads it.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			count   <= '0;
			start_q <= 1'b0;
			done    <= 1'b0;
			timeout <= 1'b0;
		end
		else if (ce)
		begin
			start_q <= start;
			timeout <= 1'b0;
			if (!start)
				done <= 1'b0;
			else if (!start_q)
				count <= reload;
			else if (!done && tick)
			begin
				if (count == '0)
				begin
					timeout <= 1'b1;
					count   <= reload;
					done    <= oneshot;
				end
				else
					count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/qgcfg_top.sv
// Global configuration register bank and interrupt aggregator.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Decode a full 8-bit address, 256 bytes of space.
// - Each channel owns 16 bytes at n*0x10, 0x00 to 0x3F.
// - Nothing answers between 0x40 and 0x7F; reads give zero.
// - Global registers at 0x80-0x8F are accessed directly.
// - Low eight offsets per channel are legacy, upper eight enhanced.
// - Pending register bit n is set while channel n requests service.
// - Pending bits 7 to 4 always read zero.
// - Pending clears when its source drops; reads of 0x84 and 0x80 clear the timer and wake flags.
// - Two source registers hold four 3-bit codes, split as documented.
// - All four interrupt registers read zero after reset.
// - Register 0x83 always reads zero.
// - Timer code 7 appears only in channel 0's field.
// - Channel interrupts gated only by the channel's own enables.
// - Timer irq masked by timer control, wake irq by sleep reg.
// - Waking after all four channels slept raises an enabled irq.
// - Bit 0 of 0x8E makes one write reach all four channels.
// - Codes: 1 rx/line, 2 rx timeout, 3 tx, 4 modem, 7 timer.
// - Reading timer control clears the pending timer interrupt.
// - Oversample bit n selects 8X for channel n when one.
// - Soft-reset bits pulse a channel reset and clear themselves.
module qgcfg_top #(
	parameter int         CHANNELS  = 4,
	parameter logic [7:0] REV_CODE  = 8'hA1, // Arbitrary value.
	parameter logic [7:0] PART_CODE = 8'h5C  // Arbitrary value.
) (
	// Clock, reset and clock enable.
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Host parallel bus.
	input  wire logic [7:0] bus_addr,
	input  wire logic       bus_rd,
	input  wire logic       bus_wr,
	input  wire logic [7:0] bus_data_in,
	output logic      [7:0] bus_data_out,
	output logic            bus_data_oe,
	// Channel register sets.
	output logic      [3:0] ch_sel,
	output logic      [3:0] ch_offset,
	output logic            ch_legacy,
	output logic            ch_rd,
	output logic            ch_wr,
	output logic      [7:0] ch_wdata,
	input  wire logic [7:0] ch_rdata,
	// Enabled interrupt requests from each channel.
	input  wire logic [3:0] ch_rx_line,
	input  wire logic [3:0] ch_rx_tout,
	input  wire logic [3:0] ch_tx_empty,
	input  wire logic [3:0] ch_modem,
	// Activity that ends full sleep, and the external timer tick.
	input  wire logic       wake_activity,
	input  wire logic       timer_ext_tick,
	// Global controls to the channels.
	output logic      [3:0] oversample_8x,
	output logic      [3:0] ch_soft_reset,
	output logic      [3:0] ch_sleep,
	output logic            all_asleep,
	// Shared interrupt.
	output logic            irq
);
	if (CHANNELS != 4)
	begin : g_bad_channels
		$error("qgcfg_top: only four channels are served");
	end

	////////////////////////////////////////////////////////////////
	localparam int TCTRL_W_L = qgcfg_pkg::TCTRL_W;
	logic [TCTRL_W_L-1:0] timer_control;
	logic [7:0]  timer_reload_low;
	logic [7:0]  timer_reload_high;
	logic [qgcfg_pkg::SLEEP_W-1:0] sleep_enable;
	logic        bcast_all;
	logic        timer_flag;
	logic        wake_flag;
	logic [3:0]  pending;
	logic [11:0] src_field;
	logic        tmr_timeout;
	logic        rd_cfg;
	logic        rd_ch;
	logic [7:0]  rd_addr;
	logic        is_ch;
	logic        is_cfg;
	logic [2:0]  code [4];
	logic [3:0]  next_pending;
	logic [11:0] next_src;
	logic [7:0]  cfg_rdata;

	assign is_ch  = (bus_addr <= qgcfg_pkg::CH_SPACE_END);
	assign is_cfg = (bus_addr >= qgcfg_pkg::CFG_BASE)
		&& (bus_addr <= qgcfg_pkg::CFG_END);

	////////////////////////////////////////////////////////////////
	// channel block select
	// Strobes to the channels are registered, so they lag one edge.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ch_sel    <= 4'h0;
			ch_offset <= 4'h0;
			ch_legacy <= 1'b0;
			ch_rd     <= 1'b0;
			ch_wr     <= 1'b0;
			ch_wdata  <= qgcfg_pkg::RST_BYTE;
		end
		else if (ce)
		begin
			ch_rd     <= bus_rd && is_ch;
			ch_wr     <= bus_wr && is_ch;
			ch_offset <= bus_addr[3:0];
			ch_legacy <= !bus_addr[qgcfg_pkg::LEGACY_BIT];
			ch_wdata  <= bus_data_in;
			if (bus_wr && bcast_all)
				ch_sel <= 4'hF;
			else
				ch_sel <= 4'h1 << bus_addr[5:4];
		end
	end

	////////////////////////////////////////////////////////////////
	// Writable global controls.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			timer_control     <= '0;
			timer_reload_low  <= qgcfg_pkg::RST_BYTE;
			timer_reload_high <= qgcfg_pkg::RST_BYTE;
			oversample_8x     <= 4'h0;
			sleep_enable      <= '0;
			bcast_all         <= 1'b0;
		end
		else if (ce && bus_wr && is_cfg)
		begin
			if (bus_addr == qgcfg_pkg::ADDR_TCTRL)
				timer_control <= bus_data_in[TCTRL_W_L-1:0];
			else if (bus_addr == qgcfg_pkg::ADDR_TLOW)
				timer_reload_low <= bus_data_in;
			else if (bus_addr == qgcfg_pkg::ADDR_THIGH)
				timer_reload_high <= bus_data_in;
			else if (bus_addr == qgcfg_pkg::ADDR_OVS)
				oversample_8x <= bus_data_in[3:0];
			else if (bus_addr == qgcfg_pkg::ADDR_SLEEP)
				sleep_enable <=
					bus_data_in[qgcfg_pkg::SLEEP_W-1:0];
			else if (bus_addr == qgcfg_pkg::ADDR_BCAST)
				bcast_all <= bus_data_in[qgcfg_pkg::BCAST_BIT];
		end
	end

	// self-clearing soft reset
	// Each bit lives for exactly one cycle after the write.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			ch_soft_reset <= 4'h0;
		else if (ce)
		begin
			if (bus_wr && bus_addr == qgcfg_pkg::ADDR_SRESET)
				ch_soft_reset <= bus_data_in[3:0];
			else
				ch_soft_reset <= 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	qgcfg_timer #(
		.WIDTH (16)
	) u_timer (
		.ref_clk (ref_clk),
		.rst     (rst),
		.ce      (ce),
		.start   (timer_control[qgcfg_pkg::TCTRL_START]),
		.oneshot (timer_control[qgcfg_pkg::TCTRL_ONESHOT]),
		.tick    (timer_control[qgcfg_pkg::TCTRL_EXTCLK]
			? timer_ext_tick : 1'b1),
		.reload  ({timer_reload_high, timer_reload_low}),
		.timeout (tmr_timeout)
	);

	// timer flag clear on read
	// A time-out in the clearing cycle wins, so no event is lost.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			timer_flag <= 1'b0;
		else if (ce)
		begin
			if (tmr_timeout
				&& timer_control[qgcfg_pkg::TCTRL_IRQ_EN])
				timer_flag <= 1'b1;
			else if (bus_rd && bus_addr == qgcfg_pkg::ADDR_TCTRL)
				timer_flag <= 1'b0;
		end
	end

	// wake after full sleep
	// A channel sleeps only with nothing pending on it; full sleep needs nothing pending on any channel.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			all_asleep <= 1'b0;
			ch_sleep   <= 4'h0;
			wake_flag  <= 1'b0;
		end
		else if (ce)
		begin
			ch_sleep <= sleep_enable[3:0] & ~pending;
			if (all_asleep && wake_activity)
			begin
				all_asleep <= 1'b0;
				if (sleep_enable[qgcfg_pkg::SLEEP_WAKE_EN])
					wake_flag <= 1'b1;
			end
			else
			begin
				all_asleep <= (sleep_enable[3:0] == 4'hF)
					&& (next_pending == 4'h0) && !wake_activity;
				if (bus_rd && bus_addr == qgcfg_pkg::ADDR_PEND)
					wake_flag <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// priority encoding
	for (genvar n = 0; n < 4; n++)
	begin : g_enc
		qgcfg_src_enc #(
			.HAS_TIMER (n == 0)
		) u_enc (
			.rx_line  (ch_rx_line[n]),
			.rx_tout  (ch_rx_tout[n]),
			.tx_empty (ch_tx_empty[n]),
			.modem    (ch_modem[n]),
			.timer    (timer_flag),
			.code     (code[n])
		);
	end

	// code 7 only on channel 0
	always_comb
	begin
		next_src = {code[3], code[2], code[1], code[0]};
		for (int n = 0; n < 4; n++)
			next_pending[n] = (code[n] != 3'b000);
		next_pending[0] = next_pending[0] || wake_flag;
	end

	// pending follows the sources
	// The registered copy trades one cycle of lag for glitch-free reads.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pending   <= 4'h0;
			src_field <= 12'h000;
			irq       <= 1'b0;
		end
		else if (ce)
		begin
			pending   <= next_pending;
			src_field <= next_src;
			irq       <= |next_pending;
		end
	end

	////////////////////////////////////////////////////////////////
	// Global read multiplexer.
	always_comb
	begin
		cfg_rdata = qgcfg_pkg::RST_BYTE;
		if (rd_addr == qgcfg_pkg::ADDR_PEND)
			cfg_rdata = {4'h0, pending};
		else if (rd_addr == qgcfg_pkg::ADDR_SRC_LO)
			cfg_rdata = src_field[7:0];
		else if (rd_addr == qgcfg_pkg::ADDR_SRC_HI)
			cfg_rdata = {4'h0, src_field[11:8]};
		else if (rd_addr == qgcfg_pkg::ADDR_SPARE)
			cfg_rdata = qgcfg_pkg::RST_BYTE;
		else if (rd_addr == qgcfg_pkg::ADDR_TCTRL)
			cfg_rdata = {4'h0, timer_control};
		else if (rd_addr == qgcfg_pkg::ADDR_TLOW)
			cfg_rdata = timer_reload_low;
		else if (rd_addr == qgcfg_pkg::ADDR_THIGH)
			cfg_rdata = timer_reload_high;
		else if (rd_addr == qgcfg_pkg::ADDR_OVS)
			cfg_rdata = {4'h0, oversample_8x};
		else if (rd_addr == qgcfg_pkg::ADDR_SLEEP)
			cfg_rdata = {3'h0, sleep_enable};
		else if (rd_addr == qgcfg_pkg::ADDR_REV)
			cfg_rdata = REV_CODE;
		else if (rd_addr == qgcfg_pkg::ADDR_PART)
			cfg_rdata = PART_CODE;
		else if (rd_addr == qgcfg_pkg::ADDR_BCAST)
			cfg_rdata = {7'h00, bcast_all};
	end

	// Two-stage read: channel data returns while ch_rd is high.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_cfg       <= 1'b0;
			rd_ch        <= 1'b0;
			rd_addr      <= qgcfg_pkg::RST_BYTE;
			bus_data_out <= qgcfg_pkg::RST_BYTE;
			bus_data_oe  <= 1'b0;
		end
		else if (ce)
		begin
			rd_cfg      <= bus_rd && !is_ch;
			rd_ch       <= bus_rd && is_ch;
			rd_addr     <= bus_addr;
			bus_data_oe <= rd_cfg || rd_ch;
			if (rd_ch)
				bus_data_out <= ch_rdata;
			else if (rd_cfg)
				bus_data_out <= cfg_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_tctrl_read;
		ce && bus_rd && bus_addr == qgcfg_pkg::ADDR_TCTRL
			&& !tmr_timeout;
	endsequence

	sequence s_all_off;
		ce [*2] ##0 !wake_flag && !timer_flag
			&& ch_rx_line == 0 && ch_rx_tout == 0
			&& ch_tx_empty == 0 && ch_modem == 0;
	endsequence

	a_pend_upper_zero: assert property (
		bus_data_oe && $past(rd_addr, 1) == qgcfg_pkg::ADDR_PEND
		|-> bus_data_out[7:4] == 4'h0)
		else $error("pending upper bits not zero");
	a_spare_reads_zero: assert property (
		ce && bus_rd && bus_addr == qgcfg_pkg::ADDR_SPARE
		##1 ce |=> bus_data_oe && bus_data_out == 8'h00)
		else $error("spare source slot not zero");
	a_timer_clears: assert property (
		s_tctrl_read |=> !timer_flag)
		else $error("timer read did not clear flag");
	a_no_code7_high: assert property (
		src_field[5:3] != 3'b111 && src_field[8:6] != 3'b111
		&& src_field[11:9] != 3'b111)
		else $error("timer code outside channel 0");
	a_irq_follows: assert property (
		ce |=> irq == (|$past(ch_rx_line | ch_rx_tout | ch_tx_empty
		| ch_modem) || $past(timer_flag) || $past(wake_flag)))
		else $error("irq does not follow the sources");
	a_pend_tracks: assert property (
		ce && ch_rx_line[2] |=> pending[2]
		&& src_field[8:6] == 3'b001)
		else $error("channel 2 pending not set");
	a_soft_pulse: assert property (
		ce && bus_wr && bus_addr == qgcfg_pkg::ADDR_SRESET
		&& bus_data_in[3:0] != 4'h0 ##1 ce
		&& !(bus_wr && bus_addr == qgcfg_pkg::ADDR_SRESET)
		|-> ch_soft_reset == $past(bus_data_in[3:0], 1)
		##1 ch_soft_reset == 4'h0)
		else $error("soft reset not self clearing");
	a_bcast_all: assert property (
		ce && bus_wr && is_ch && bcast_all
		|=> ch_wr && ch_sel == 4'hF)
		else $error("broadcast write missed a channel");
	a_reserved_zero: assert property (
		ce && bus_rd && bus_addr > qgcfg_pkg::CH_SPACE_END
		&& bus_addr <= qgcfg_pkg::RSVD_END ##1 ce
		|-> !ch_rd ##1 bus_data_oe && bus_data_out == 8'h00)
		else $error("reserved range answered");
	a_idle_clear: assert property (
		s_all_off |=> pending == 4'h0)
		else $error("pending stuck without source");
endmodule
`default_nettype wire

// File: tb/qgcfg_chan_model.sv
// Behavioural register sets of the four channels, answering channel reads.
`timescale 1ns/1ps
`default_nettype none
module qgcfg_chan_model (
	// Clock.
	input  wire logic       ref_clk,
	// Channel side of the block.
	input  wire logic [3:0] ch_sel,
	input  wire logic [3:0] ch_offset,
	input  wire logic       ch_legacy,
	input  wire logic       ch_rd,
	output logic      [7:0] ch_rdata
);
	logic [7:0] churn = 8'h5A;

	////////////////////////////////////////////////////////////////////////
	// Outside a read the bus churns, so a late or early capture shows up.
	always_ff @(posedge ref_clk)
	begin
		churn <= churn + 8'h3D;
	end

	// Read data encodes which register was selected and which half.
	assign ch_rdata = ch_rd ? ({ch_sel, ch_offset} ^ {7'h00, ch_legacy}) : churn;
endmodule
`default_nettype wire

// File: tb/qgcfg_top_tb.sv
// Self-checking bench for the global configuration block.
`timescale 1ns/1ps
`default_nettype none
module qgcfg_top_tb;
	localparam logic [7:0] REV  = 8'h3B; // Arbitrary value.
	localparam logic [7:0] PART = 8'h6E; // Arbitrary value.
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  bus_addr = 8'h00;
	logic        bus_rd = 1'b0;
	logic        bus_wr = 1'b0;
	logic [7:0]  bus_data_in = 8'h00;
	logic [15:0] rq = 16'h0000;
	logic        wake_activity = 1'b0;
	logic        ce = 1'b1;
	logic        ext_tick = 1'b0;
	wire  logic [7:0] bus_data_out;
	wire  logic [7:0] ch_wdata;
	wire  logic [7:0] ch_rdata;
	wire  logic [3:0] ch_sel;
	wire  logic [3:0] ch_offset;
	wire  logic [3:0] oversample_8x;
	wire  logic [3:0] ch_soft_reset;
	wire  logic [3:0] ch_sleep;
	wire  logic       bus_data_oe;
	wire  logic       ch_legacy;
	wire  logic       ch_rd;
	wire  logic       ch_wr;
	wire  logic       all_asleep;
	wire  logic       irq;
	logic [7:0]  exp_q [$];
	logic [7:0]  adr_q [$];
	logic [11:0] fld;
	logic [3:0]  pnd;
	logic [7:0]  rv;
	logic [7:0]  holes [8] = '{8'h40, 8'h7F, 8'h83, 8'h85, 8'h89, 8'h8A,
		8'h90, 8'hFF};
	logic [7:0]  chad [4] = '{8'h03, 8'h13, 8'h2C, 8'h3F};
	int          seed = 32'hefe28e3c;
	int          err_total = 0;
	int          checked = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock at 50 MHz.
	always #10 ref_clk = ~ref_clk;

	// Device under test; clock enable and timer tick come from the bench.
	qgcfg_top #(.REV_CODE(REV), .PART_CODE(PART)) u_qgcfg_top (
		.ref_clk(ref_clk), .rst(rst), .ce(ce),
		.bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
		.bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
		.bus_data_oe(bus_data_oe), .ch_sel(ch_sel), .ch_offset(ch_offset),
		.ch_legacy(ch_legacy), .ch_rd(ch_rd), .ch_wr(ch_wr),
		.ch_wdata(ch_wdata), .ch_rdata(ch_rdata),
		.ch_rx_line(rq[3:0]), .ch_rx_tout(rq[7:4]),
		.ch_tx_empty(rq[11:8]), .ch_modem(rq[15:12]),
		.wake_activity(wake_activity), .timer_ext_tick(ext_tick),
		.oversample_8x(oversample_8x), .ch_soft_reset(ch_soft_reset),
		.ch_sleep(ch_sleep), .all_asleep(all_asleep), .irq(irq)
	);

	// Channel register sets on the far side.
	qgcfg_chan_model u_qgcfg_chan_model (
		.ref_clk(ref_clk), .ch_sel(ch_sel), .ch_offset(ch_offset),
		.ch_legacy(ch_legacy), .ch_rd(ch_rd), .ch_rdata(ch_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Highest-priority source code of one channel from the request levels.
	function automatic logic [2:0] code_of(input int ch);
		for (int k = 0; k < 4; k++)
			if (rq[4 * k + ch])
				return 3'(k + 1);
		return 3'd0;
	endfunction

	task automatic summarize();
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// A read notes its expectation; the watcher compares the answer.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		bus_addr = a;
		bus_rd = 1'b1;
		exp_q.push_back(exp);
		adr_q.push_back(a);
		@(negedge ref_clk);
		bus_rd = 1'b0;
	endtask

	// Returns at the negedge after the taking edge, with outputs updated.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus_addr = a;
		bus_data_in = d;
		bus_wr = 1'b1;
		@(negedge ref_clk);
		bus_wr = 1'b0;
	endtask

	// Bounded wait for the interrupt (0) or for the all-asleep flag (1).
	task automatic await(input bit which);
		int n;
		for (n = 0; n < 200; n++)
		begin
			if ((which ? all_asleep : irq) === 1'b1)
				break;
			@(negedge ref_clk);
		end
		if (n == 200)
		begin
			err_total++;
			summarize();
		end
	endtask

	// Each read answer is matched against the oldest noted expectation.
	always @(negedge ref_clk)
	begin
		if (bus_data_oe === 1'b1)
		begin
			if (exp_q.size() > 0)
				chk($sformatf("read %h", adr_q.pop_front()), bus_data_out,
					exp_q.pop_front());
			else
				chk("read answer count", 8'h01, 8'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		for (int i = 0; i < 4; i++)
			rd(8'h80 + 8'(i), 8'h00);
		wr(8'h40, 8'hFF);
		for (int i = 0; i < 8; i++)
			rd(holes[i], 8'h00);
		for (int i = 0; i < 4; i++)
			rd(chad[i], {4'h1 << chad[i][5:4], chad[i][3:0]}
				^ {7'h00, ~chad[i][3]});
		// Single sources walk codes 1 to 4 on every channel, then random mixes.
		for (int i = 0; i < 24; i++)
		begin
			@(negedge ref_clk);
			rq = (i < 16) ? 16'h0001 << i : 16'($random(seed));
			fld = {code_of(3), code_of(2), code_of(1), code_of(0)};
			pnd = rq[3:0] | rq[7:4] | rq[11:8] | rq[15:12];
			idle(2);
			chk("irq", {7'h00, irq}, {7'h00, |pnd});
			rd(8'h80, {4'h0, pnd});
			rd(8'h81, fld[7:0]);
			rd(8'h82, {4'h0, fld[11:8]});
		end
		@(negedge ref_clk);
		rq = 16'h0000;
		// Timer runs masked first, then enabled.
		wr(8'h86, 8'h04);
		wr(8'h87, 8'h00);
		wr(8'h84, 8'h02);
		idle(30);
		rd(8'h80, 8'h00);
		wr(8'h84, 8'h03);
		await(0);
		rd(8'h80, 8'h01);
		rd(8'h81, 8'h07);
		rd(8'h82, 8'h00);
		wr(8'h84, 8'h00);
		rd(8'h84, 8'h00);
		idle(3);
		rd(8'h81, 8'h00);
		// External ticks: a one-shot time-out takes reload plus one ticks.
		wr(8'h84, 8'h0F);
		idle(2);
		ext_tick = 1'b1;
		idle(4);
		ext_tick = 1'b0;
		idle(3);
		rd(8'h80, 8'h00);
		ext_tick = 1'b1;
		@(negedge ref_clk);
		ext_tick = 1'b0;
		await(0);
		rd(8'h81, 8'h07);
		rd(8'h84, 8'h0F);
		// One-shot has stopped, so further ticks raise nothing.
		ext_tick = 1'b1;
		idle(8);
		ext_tick = 1'b0;
		idle(2);
		rd(8'h80, 8'h00);
		wr(8'h84, 8'h00);
		// Oversampling select, soft reset and broadcast writes.
		rv = 8'($random(seed));
		wr(8'h88, rv);
		chk("oversample_8x", {4'h0, oversample_8x}, {4'h0, rv[3:0]});
		rd(8'h88, {4'h0, rv[3:0]});
		// A low clock enable freezes the block, so this write is lost.
		idle(2);
		ce = 1'b0;
		wr(8'h88, ~rv);
		chk("oversample_8x", {4'h0, oversample_8x}, {4'h0, rv[3:0]});
		ce = 1'b1;
		wr(8'h8A, 8'h05);
		chk("ch_soft_reset", {4'h0, ch_soft_reset}, 8'h05);
		@(negedge ref_clk);
		chk("ch_soft_reset", {4'h0, ch_soft_reset}, 8'h00);
		wr(8'h8E, 8'h01);
		rd(8'h8E, 8'h01);
		wr(8'h25, 8'h5A);
		chk("ch_sel", {4'h0, ch_sel}, 8'h0F);
		chk("ch_wr", {7'h00, ch_wr}, 8'h01);
		chk("ch_wdata", ch_wdata, 8'h5A);
		wr(8'h8E, 8'h00);
		wr(8'h2D, 8'hC3);
		chk("ch_sel", {4'h0, ch_sel}, 8'h04);
		chk("ch_offset", {4'h0, ch_offset}, 8'h0D);
		chk("ch_legacy", {7'h00, ch_legacy}, 8'h00);
		// Identification is read-only.
		wr(8'h8C, 8'hFF);
		rd(8'h8C, REV);
		rd(8'h8D, PART);
		// Partial sleep spares the pending channel and is not full sleep.
		rq = 16'h0004;
		wr(8'h8B, 8'h17);
		idle(2);
		chk("ch_sleep", {4'h0, ch_sleep}, 8'h03);
		chk("all_asleep", {7'h00, all_asleep}, 8'h00);
		rq = 16'h0000;
		// All channels asleep, then woken by activity.
		wr(8'h8B, 8'h1F);
		await(1);
		chk("ch_sleep", {4'h0, ch_sleep}, 8'h0F);
		@(negedge ref_clk);
		wake_activity = 1'b1;
		@(negedge ref_clk);
		wake_activity = 1'b0;
		await(0);
		wr(8'h8B, 8'h00);
		rd(8'h81, 8'h00);
		rd(8'h80, 8'h01);
		idle(3);
		rd(8'h80, 8'h00);
		chk("irq", {7'h00, irq}, 8'h00);
		idle(5);
		chk("open reads", 8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
